// ---- rtl/pss_top.sv ----
// pss_top: process regulator with start delay, sleep and wake, apb registers.
// assumes same-clock feedback words and asynchronous contact pins.
//
// Overview of operation
// (RQ1) nonzero start delay holds regulation off
// (RQ2) during delay, run open loop from source
// (RQ3) polarity 0 raises frequency when feedback low
// (RQ4) invert pin or polarity bit inverts
// (RQ5) error wake after wake delay
// (RQ6) feedback threshold wake after wake delay
// (RQ7) frequency wake at sleep frequency plus hysteresis
// (RQ8) wake priority error, absolute, percent, frequency
// (RQ9) wake thresholds are absolute; percent of setpoint
// (RQ10) software keeps hysteresis nonzero for frequency sleep
// (RQ11) sleep action stops or holds lower limit
// (RQ12) threshold sleep after sleep delay
// (RQ13) frequency sleep needs feedback and frequency
// (RQ14) threshold sleep beats frequency sleep
// (RQ15) zero sleep delay disables sleep
// (RQ16) sleep percentages reference the setpoint
// (RQ17) clamp setpoint to limits of sensor range
// (RQ18) dead band suspends regulator
// (RQ19) gains held within their ranges
// (RQ20) keypad keys and register set setpoint
// (RQ21) setpoint bounded by sensor range
// (RQ22) enable select 0 off, 1 or 2 input
// (RQ23) duration timers restart when condition drops
// (RQ24) all evaluation on a periodic tick; regulating, sleeping and timer restarts change on any pclk
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module pss_top #(
    parameter int TICK_CYCLES = pss_pkg::TICK_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic run_pin,
    input wire logic invert_pin,
    input wire logic key_up_pin,
    input wire logic key_down_pin,
    input wire logic [15:0] ai1_feedback,
    input wire logic [15:0] ai2_feedback,
    input wire logic [15:0] ext_freq_ref,
    output logic [15:0] freq_cmd,
    output logic sleeping,
    output logic regulating
);
    if (TICK_CYCLES < 1) begin : g_chk
        $error("pss_top: TICK_CYCLES must be at least 1");
    end

    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
        logic [3:0] s3;
        logic [3:0] pin;
        logic [pss_pkg::CFG_N-1:0][31:0] cfg;
        logic [31:0] prdata;
        logic pslverr;
        logic [31:0] tcnt;
        logic tick;
        logic sleeping;
        logic regulating;
        logic signed [16:0] e1;
        logic signed [16:0] e2;
        logic [15:0] pid_f;
        logic [15:0] out_f;
    } pss_state_t;

    pss_state_t q;
    pss_state_t d;

    function automatic logic [15:0] pct_of(input logic [15:0] v, input logic [15:0] p);
        logic [31:0] prod;
        prod = {16'h0000, v} * {16'h0000, p};
        return 16'(prod / 32'(pss_pkg::PCT_FULL));
    endfunction : pct_of

    // ----------------------------------------
    // settings
    // ----------------------------------------
    wire [1:0] sel = q.cfg[pss_pkg::I_CTRL][1:0];
    wire en = (sel == 2'h1) || (sel == 2'h2); // [RQ22]
    wire pol = q.cfg[pss_pkg::I_CTRL][pss_pkg::CTRL_POL_BIT];
    wire act = q.cfg[pss_pkg::I_CTRL][pss_pkg::CTRL_ACT_BIT];
    wire [2:0] src = q.cfg[pss_pkg::I_CTRL][pss_pkg::CTRL_SRC_LSB+:3];
    wire [15:0] kp = q.cfg[pss_pkg::I_GAIN][15:0];
    wire [15:0] ki = q.cfg[pss_pkg::I_GAIN][31:16];
    wire [7:0] kd = q.cfg[pss_pkg::I_DS][7:0];
    wire [11:0] sdly = q.cfg[pss_pkg::I_DS][27:16];
    wire [15:0] sr = q.cfg[pss_pkg::I_SENS][15:0];
    wire [15:0] sp_raw = q.cfg[pss_pkg::I_SENS][31:16];
    wire [15:0] ew = q.cfg[pss_pkg::I_WTH][15:0];
    wire [15:0] fw = q.cfg[pss_pkg::I_WTH][31:16];
    wire [15:0] pwl = q.cfg[pss_pkg::I_WCFG][15:0];
    wire [15:0] wdly = q.cfg[pss_pkg::I_WCFG][31:16];
    wire [15:0] thr = q.cfg[pss_pkg::I_SLP][15:0];
    wire [15:0] sldly = q.cfg[pss_pkg::I_SLP][31:16];
    wire [15:0] tol = q.cfg[pss_pkg::I_SLP2][15:0];
    wire [15:0] dbp = q.cfg[pss_pkg::I_SLP2][31:16];
    wire [15:0] maxf = q.cfg[pss_pkg::I_FRA][15:0];
    wire [15:0] slf = q.cfg[pss_pkg::I_FRA][31:16];
    wire [15:0] upf = q.cfg[pss_pkg::I_FRB][15:0];
    wire [15:0] lof = q.cfg[pss_pkg::I_FRB][31:16];
    wire [15:0] hys = q.cfg[pss_pkg::I_HYS][15:0];
    wire run = q.pin[0];
    wire inv = pol | q.pin[1]; // [RQ4]

    // ----------------------------------------
    // process values
    // ----------------------------------------
    wire [15:0] sp_hi = pct_of(sr, q.cfg[pss_pkg::I_SPLIM][15:0]);
    wire [15:0] sp_lo = pct_of(sr, q.cfg[pss_pkg::I_SPLIM][31:16]);
    wire [15:0] sp_c = (sp_raw > sp_hi) ? sp_hi : ((sp_raw < sp_lo) ? sp_lo : sp_raw);
    wire [15:0] sp = en ? sp_c : sp_raw; // [RQ17]
    wire [15:0] fb = (sel == 2'h2) ? ai2_feedback : ai1_feedback; // [RQ22]
    wire signed [16:0] e_raw = $signed({1'b0, sp}) - $signed({1'b0, fb});
    wire signed [16:0] e = inv ? -e_raw : e_raw; // [RQ3] [RQ4]
    wire [16:0] mag = e_raw[16] ? 17'(-e_raw) : 17'(e_raw);
    wire in_band = mag <= {1'b0, pct_of(sp, dbp)}; // [RQ18]

    // ----------------------------------------
    // sleep and wake conditions
    // ----------------------------------------
    wire slp_thr = fb > pct_of(sp, thr); // [RQ12] [RQ16]
    wire slp_frq = ({1'b0, fb} >= ({1'b0, sp} - {1'b0, pct_of(sp, tol)}))
        && (q.pid_f <= slf); // [RQ13] [RQ16]
    wire slp_raw = (thr != 16'h0000) ? slp_thr : slp_frq; // [RQ14]
    wire sleep_en = (sldly != 16'h0000) && q.regulating; // [RQ15]
    wire wk_err = e_raw > $signed({1'b0, ew}); // [RQ5] [RQ9]
    wire wk_abs = fb > fw; // [RQ6] [RQ9]
    wire wk_pct = fb > pct_of(sp, pwl); // [RQ6] [RQ9]
    wire wk_frq = {1'b0, q.pid_f} >= ({1'b0, slf} + {1'b0, hys}); // [RQ7]
    wire wake_raw = (ew != 16'h0000) ? wk_err : (fw != 16'h0000) ? wk_abs :
        (pwl != 16'h0000) ? wk_pct : wk_frq; // [RQ8]

    logic start_done;
    logic slp_done;
    logic wk_done;
    wire [15:0] sd_ticks = 16'({4'h0, sdly} * 16'(pss_pkg::TICKS_PER_SEC));

    pss_dur_timer #(.W(16)) u_start (
        .pclk(pclk),
        .presetn(presetn),
        .tick(q.tick),
        .cond(run && en),
        .limit(sd_ticks),
        .done(start_done)
    ); // [RQ1]

    pss_dur_timer #(.W(16)) u_sleep (
        .pclk(pclk),
        .presetn(presetn),
        .tick(q.tick),
        .cond(sleep_en && !q.sleeping && slp_raw),
        .limit(sldly),
        .done(slp_done)
    ); // [RQ12] [RQ13]

    pss_dur_timer #(.W(16)) u_wake (
        .pclk(pclk),
        .presetn(presetn),
        .tick(q.tick),
        .cond(q.sleeping && wake_raw),
        .limit(wdly),
        .done(wk_done)
    ); // [RQ5] [RQ6] [RQ7]

    // ----------------------------------------
    // regulator arithmetic
    // ----------------------------------------
    wire [31:0] ol_prod = {16'h0000, maxf} * {16'h0000, sp_raw};
    wire [15:0] ol_calc = (sr == 16'h0000) ? 16'h0000 : 16'(ol_prod / {16'h0000, sr});
    wire [15:0] tgt = !run ? 16'h0000 :
        (en && src == pss_pkg::SRC_KEYPAD) ? ol_calc : ext_freq_ref; // [RQ2]
    wire signed [17:0] de = 18'(e) - 18'(q.e1);
    wire signed [18:0] dde = 19'(e) - 19'(q.e1) - 19'(q.e1) + 19'(q.e2);
    wire signed [39:0] delta = $signed({1'b0, kp}) * de + $signed({1'b0, ki}) * e
        + $signed({1'b0, kd}) * dde;
    wire signed [39:0] nf = $signed({24'h0, q.pid_f}) + delta / 40'(pss_pkg::GAIN_ONE);
    wire [15:0] nf_c = (nf > $signed({24'h0, upf})) ? upf :
        (nf < $signed({24'h0, lof})) ? lof : nf[15:0];

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic [3:0] pin_n;
        logic [3:0] ind;
        d = q;
        pin_n = (q.s2 & q.s3) | (q.pin & (q.s2 ^ q.s3));
        ind = paddr[5:2];
        d.s1 = {key_down_pin, key_up_pin, invert_pin, run_pin};
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.pin = pin_n;
        // periodic evaluation tick
        d.tick = (q.tcnt == 32'(TICK_CYCLES - 1)); // [RQ24]
        d.tcnt = d.tick ? 32'h0000_0000 : q.tcnt + 32'h0000_0001;
        // keypad arrows move the same setpoint word as the bus
        if (pin_n[2] && !q.pin[2] && sp_raw < sr) begin
            d.cfg[pss_pkg::I_SENS][31:16] = sp_raw + 16'h0001; // [RQ20]
        end
        if (pin_n[3] && !q.pin[3] && sp_raw != 16'h0000) begin
            d.cfg[pss_pkg::I_SENS][31:16] = sp_raw - 16'h0001; // [RQ20]
        end
        // apb: decode in setup, write at the access edge
        if (psel && !penable) begin
            d.pslverr = (paddr >= pss_pkg::OFF_END) || (paddr[1:0] != 2'h0);
            if (paddr < pss_pkg::OFF_STATUS) begin
                d.prdata = q.cfg[ind];
            end else if (paddr == pss_pkg::OFF_STATUS) begin
                d.prdata = {q.out_f, 13'h0000, inv, q.regulating, q.sleeping};
            end else if (paddr == pss_pkg::OFF_PROC) begin
                d.prdata = {sp, fb};
            end else begin
                d.prdata = 32'h0000_0000;
            end
        end
        if (psel && penable && pwrite && !q.pslverr && paddr < pss_pkg::OFF_STATUS) begin
            d.cfg[ind] = pwdata & pss_pkg::CFG_MASK[ind];
        end
        // range clamps applied to whatever was stored
        if (d.cfg[pss_pkg::I_GAIN][15:0] < pss_pkg::KP_MIN) begin
            d.cfg[pss_pkg::I_GAIN][15:0] = pss_pkg::KP_MIN; // [RQ19]
        end
        if (d.cfg[pss_pkg::I_GAIN][15:0] > pss_pkg::KP_MAX) begin
            d.cfg[pss_pkg::I_GAIN][15:0] = pss_pkg::KP_MAX; // [RQ19]
        end
        if (d.cfg[pss_pkg::I_GAIN][31:16] < pss_pkg::KP_MIN) begin
            d.cfg[pss_pkg::I_GAIN][31:16] = pss_pkg::KP_MIN; // [RQ19]
        end
        if (d.cfg[pss_pkg::I_GAIN][31:16] > pss_pkg::KP_MAX) begin
            d.cfg[pss_pkg::I_GAIN][31:16] = pss_pkg::KP_MAX; // [RQ19]
        end
        if (d.cfg[pss_pkg::I_SENS][31:16] > d.cfg[pss_pkg::I_SENS][15:0]) begin
            d.cfg[pss_pkg::I_SENS][31:16] = d.cfg[pss_pkg::I_SENS][15:0]; // [RQ21]
        end
        // regulation state
        d.regulating = run && en && start_done; // [RQ1]
        if (!q.regulating) begin
            d.sleeping = 1'b0;
        end else if (q.sleeping && wk_done) begin
            d.sleeping = 1'b0;
        end else if (!q.sleeping && slp_done) begin
            d.sleeping = 1'b1;
        end
        if (q.tick) begin
            if (!q.regulating) begin
                // preload history so closing the loop gives no derivative kick
                d.e1 = e;
                d.e2 = e;
                if (q.pid_f + pss_pkg::RAMP_STEP < tgt) begin
                    d.pid_f = q.pid_f + pss_pkg::RAMP_STEP; // [RQ2]
                end else if (q.pid_f > tgt + pss_pkg::RAMP_STEP) begin
                    d.pid_f = q.pid_f - pss_pkg::RAMP_STEP;
                end else begin
                    d.pid_f = tgt;
                end
            end else if (!in_band) begin
                d.pid_f = nf_c; // [RQ3]
                d.e1 = e;
                d.e2 = q.e1;
            end
        end
        // output stage: sleep overrides the regulator
        if (!q.sleeping) begin
            d.out_f = q.pid_f;
        end else if (act) begin
            d.out_f = lof; // [RQ11]
        end else if (q.tick) begin
            d.out_f = (q.out_f > pss_pkg::RAMP_STEP) ? q.out_f - pss_pkg::RAMP_STEP : 16'h0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.cfg <= pss_pkg::CFG_RST;
        end else begin
            q <= d;
        end
    end

    assign pready = 1'b1;
    assign prdata = q.prdata;
    assign pslverr = q.pslverr;
    assign freq_cmd = q.out_f;
    assign sleeping = q.sleeping;
    assign regulating = q.regulating;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_start_hold;
        @(posedge pclk) disable iff (!presetn)
        (run && en && !start_done) |=> !q.regulating;
    endproperty
    a_start_hold: assert property (p_start_hold) // [RQ1]
        else $error("regulating before start delay elapsed");

    property p_direction;
        @(posedge pclk) disable iff (!presetn)
        (q.tick && q.regulating && !in_band && e == q.e1 && q.e1 == q.e2)
            |=> (($past(inv) ^ ($past(e_raw) > 0)) ? q.pid_f >= $past(q.pid_f)
            : q.pid_f <= $past(q.pid_f));
    endproperty
    a_direction: assert property (p_direction) // [RQ3]
        else $error("frequency moved against the error");

    property p_dead_band;
        @(posedge pclk) disable iff (!presetn)
        (q.tick && q.regulating && in_band) |=> $stable(q.pid_f);
    endproperty
    a_dead_band: assert property (p_dead_band) // [RQ18]
        else $error("regulator acted inside dead band");

    property p_setpoint_clamp;
        @(posedge pclk) disable iff (!presetn)
        (en && sp_lo <= sp_hi) |-> (sp >= sp_lo && sp <= sp_hi);
    endproperty
    a_setpoint_clamp: assert property (p_setpoint_clamp) // [RQ17]
        else $error("setpoint outside limits");

    property p_no_sleep;
        @(posedge pclk) disable iff (!presetn)
        (sldly == 16'h0000 && !q.sleeping) |=> !q.sleeping;
    endproperty
    a_no_sleep: assert property (p_no_sleep) // [RQ15]
        else $error("sleep entered with zero sleep delay");

    property p_sleep_hold;
        @(posedge pclk) disable iff (!presetn)
        (q.sleeping && act) ##1 q.sleeping |-> (q.out_f == $past(lof));
    endproperty
    a_sleep_hold: assert property (p_sleep_hold) // [RQ11]
        else $error("sleep action 1 not at lower limit");

    property p_sleep_decel;
        @(posedge pclk) disable iff (!presetn)
        (q.sleeping && !act && q.tick && q.out_f != 16'h0000) |=> q.out_f < $past(q.out_f);
    endproperty
    a_sleep_decel: assert property (p_sleep_decel) // [RQ11]
        else $error("sleep action 0 did not decelerate");

    property p_wake_prio;
        @(posedge pclk) disable iff (!presetn)
        (ew != 16'h0000) |-> (wake_raw == (e_raw > $signed({1'b0, ew})));
    endproperty
    a_wake_prio: assert property (p_wake_prio) // [RQ8]
        else $error("error wake not given priority");

    property p_unmapped;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && paddr >= pss_pkg::OFF_END) |=> (pslverr && prdata == 32'h0);
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped address not refused");

endmodule : pss_top

// ---- common/pss_pkg.sv ----
// pss_pkg: constants for the process regulator with sleep and wake.
// assumes a 25 MHz pclk and an apb master with 32-bit data.
package pss_pkg;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int TICK_PERIOD_MS = 100;
    localparam int TICK_CYCLES = TICK_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
    localparam int TICKS_PER_SEC = 1000 / TICK_PERIOD_MS;

    // ----------------------------------------
    // scaling
    // ----------------------------------------
    localparam int PCT_FULL = 1000;
    localparam int GAIN_ONE = 100;
    localparam logic [15:0] KP_MIN = 16'h0001;
    localparam logic [15:0] KP_MAX = 16'h2710;
    localparam logic [15:0] RAMP_STEP = 16'h000a;
    localparam logic [2:0] SRC_KEYPAD = 3'h7;

    // ----------------------------------------
    // register map (cfg word i sits at byte 4*i)
    // ----------------------------------------
    localparam int CFG_N = 12;
    localparam int I_CTRL = 0;
    localparam int I_GAIN = 1;
    localparam int I_DS = 2;
    localparam int I_SENS = 3;
    localparam int I_SPLIM = 4;
    localparam int I_WTH = 5;
    localparam int I_WCFG = 6;
    localparam int I_SLP = 7;
    localparam int I_SLP2 = 8;
    localparam int I_FRA = 9;
    localparam int I_FRB = 10;
    localparam int I_HYS = 11;
    localparam logic [7:0] OFF_STATUS = 8'h30;
    localparam logic [7:0] OFF_PROC = 8'h34;
    localparam logic [7:0] OFF_END = 8'h38;

    // ctrl fields
    localparam int CTRL_POL_BIT = 2;
    localparam int CTRL_ACT_BIT = 3;
    localparam int CTRL_SRC_LSB = 4;

    // values after reset, word 11 first
    localparam logic [CFG_N-1:0][31:0] CFG_RST = '{
        32'h0000_0014, 32'h0000_1388, 32'h0000_1388, 32'h0000_0000,
        32'h0001_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_03e8,
        32'h0000_0064, 32'h0000_0000, 32'h0064_0064, 32'h0000_0000};
    localparam logic [CFG_N-1:0][31:0] CFG_MASK = '{
        32'h0000_ffff, 32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff,
        32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff,
        32'hffff_ffff, 32'h0fff_00ff, 32'hffff_ffff, 32'h0000_007f};

endpackage : pss_pkg

// ---- rtl/pss_dur_timer.sv ----
// pss_dur_timer: counts ticks while a condition holds.
// assumes tick is a one-cycle pulse on pclk.
`timescale 1ns/1ps
module pss_dur_timer #(
    parameter int W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tick,
    input wire logic cond,
    input wire logic [W-1:0] limit,
    output logic done
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } pss_tmr_state_t;

    pss_tmr_state_t q;
    pss_tmr_state_t d;

    if (W < 1) begin : g_chk
        $error("pss_dur_timer: W must be at least 1");
    end

    // ----------------------------------------
    // counter
    // ----------------------------------------
    always_comb begin
        d = q;
        if (!cond) begin
            d.cnt = '0; // [RQ23]
        end else if (tick && q.cnt < limit) begin
            d.cnt = q.cnt + 1'b1;
        end
    end

    assign done = cond && (q.cnt >= limit);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    property p_restart;
        @(posedge pclk) disable iff (!presetn)
        !cond |=> (q.cnt == '0);
    endproperty
    a_restart: assert property (p_restart) // [RQ23]
        else $error("timer not restarted after condition dropped");

endmodule : pss_dur_timer

// ---- verification/pss_plant.sv ----
// pss_plant: behavioural process sensor and motor stage on the far side.
// assumes the bench sets the process value; everything on one pclk.
`timescale 1ns/1ps
module pss_plant (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [15:0] process_value,
    input wire logic [15:0] freq_cmd,
    output logic [15:0] ai1_feedback,
    output logic [15:0] ai2_feedback,
    output logic [15:0] motor_speed
);
    // --------
    // sensor and motor
    // --------
    // second input moves every cycle, so a wrong feedback select shows up
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ai2_feedback <= 16'h5a5a;
            motor_speed <= 16'h0000;
        end else begin
            ai2_feedback <= ~ai2_feedback;
            motor_speed <= freq_cmd;
        end
    end
    assign ai1_feedback = process_value;
endmodule : pss_plant

// ---- verification/pss_top_tb_top.sv ----
// pss_top_tb_top: directed bench for regulator, sleep, wake and apb registers.
// assumes pss_plant as the sensor and a short tick of 10 pclk.
`timescale 1ns/1ps
module pss_top_tb_top;
    localparam int TK = 10;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic run_pin = 1'b0;
    logic invert_pin = 1'b0;
    logic key_up_pin = 1'b0;
    logic key_down_pin = 1'b0;
    logic [15:0] pv = 16'h0000;
    logic [15:0] ai1;
    logic [15:0] ai2;
    logic [15:0] freq_cmd;
    logic [15:0] f0;
    logic sleeping;
    logic regulating;
    logic [31:0] rdv;
    logic rde;
    int n_errors = 0;
    int n_compared = 0;
    int cyc = 0;

    always #20 pclk = ~pclk;

    pss_top #(.TICK_CYCLES(TK)) pss_top_i (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .run_pin(run_pin),
        .invert_pin(invert_pin), .key_up_pin(key_up_pin),
        .key_down_pin(key_down_pin), .ai1_feedback(ai1), .ai2_feedback(ai2),
        .ext_freq_ref(16'h0000), .freq_cmd(freq_cmd), .sleeping(sleeping),
        .regulating(regulating));
    pss_plant pss_plant_i (.pclk(pclk), .presetn(presetn), .process_value(pv),
        .freq_cmd(freq_cmd), .ai1_feedback(ai1), .ai2_feedback(ai2), .motor_speed());

    // --------
    // helpers
    // --------
    task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", w, e, g);
        end
    endtask : chk
    task automatic flag(input string w, input logic e, input logic g);
        chk(w, {31'h0, e}, {31'h0, g});
    endtask : flag
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdv = prdata;
        rde = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        apb(a, 1'b0, 32'h0);
    endtask : rd
    // ends at a falling edge so outputs are settled when looked at
    task automatic tk(input int n);
        repeat (n * TK) @(posedge pclk);
        @(negedge pclk);
    endtask : tk
    task automatic setpv(input logic [15:0] v);
        @(posedge pclk);
        pv <= v;
    endtask : setpv
    task automatic dir(input string w, input logic up);
        logic [15:0] a;
        @(negedge pclk);
        a = freq_cmd;
        tk(5);
        flag(w, 1'b1, up ? freq_cmd > a : freq_cmd < a);
    endtask : dir
    task automatic key(input logic up);
        @(posedge pclk);
        key_up_pin <= up;
        key_down_pin <= !up;
        repeat (8) @(posedge pclk);
        key_up_pin <= 1'b0;
        key_down_pin <= 1'b0;
        repeat (8) @(posedge pclk);
    endtask : key

    // --------
    // scenarios
    // --------
    task automatic t_regs();
        rd(8'h2c);
        chk("hysteresis reset", 32'h0000_0014, rdv);
        rd(8'h1c);
        chk("sleep delay reset", 32'h0000_0001, {16'h0, rdv[31:16]});
        wr(8'h04, 32'h0000_0000);
        rd(8'h04);
        chk("gain floor", 32'h0001_0001, rdv);
        wr(8'h04, 32'hffff_ffff);
        rd(8'h04);
        chk("gain ceiling", 32'h2710_2710, rdv);
        wr(8'h04, 32'h0064_0064);
        rd(8'h38);
        flag("unmapped error", 1'b1, rde);
        rd(8'h06);
        flag("misaligned error", 1'b1, rde);
        $display("test regs done");
    endtask : t_regs
    task automatic t_start();
        wr(8'h00, 32'h0000_0071);
        wr(8'h0c, 32'h0032_0064);
        wr(8'h08, 32'h0001_0000);
        run_pin <= 1'b1;
        tk(5);
        flag("regulating in delay", 1'b0, regulating);
        f0 = freq_cmd;
        tk(1);
        chk("open loop ramp", {16'h0, f0 + 16'h000a}, {16'h0, freq_cmd});
        tk(7);
        flag("regulating after delay", 1'b1, regulating);
        $display("test start delay done");
    endtask : t_start
    task automatic t_pol();
        tk(10);
        dir("rise at polarity 0", 1'b1);
        wr(8'h00, 32'h0000_0075);
        dir("fall at polarity 1", 1'b0);
        wr(8'h00, 32'h0000_0071);
        invert_pin <= 1'b1;
        dir("fall with invert pin", 1'b0);
        rd(8'h30);
        flag("inversion status", 1'b1, rdv[2]);
        invert_pin <= 1'b0;
        $display("test polarity done");
    endtask : t_pol
    task automatic t_dband();
        setpv(16'h0014);
        wr(8'h20, 32'h0320_0000);
        tk(2);
        f0 = freq_cmd;
        tk(4);
        chk("hold in dead band", {16'h0, f0}, {16'h0, freq_cmd});
        wr(8'h20, 32'h0064_0000);
        dir("act outside dead band", 1'b1);
        wr(8'h20, 32'h0000_0000);
        $display("test dead band done");
    endtask : t_dband
    task automatic t_clamp();
        wr(8'h10, 32'h0000_012c);
        tk(2);
        rd(8'h34);
        chk("clamp to upper", 32'h0000_001e, {16'h0, rdv[31:16]});
        chk("feedback input one", 32'h0000_0014, {16'h0, rdv[15:0]});
        wr(8'h10, 32'h0258_03e8);
        tk(2);
        rd(8'h34);
        chk("clamp to lower", 32'h0000_003c, {16'h0, rdv[31:16]});
        wr(8'h10, 32'h0000_03e8);
        wr(8'h0c, 32'h00c8_0064);
        rd(8'h0c);
        chk("setpoint bound", 32'h0064_0064, rdv);
        wr(8'h0c, 32'h0032_0064);
        key(1'b1);
        key(1'b1);
        key(1'b0);
        rd(8'h0c);
        chk("keypad setpoint", 32'h0000_0033, {16'h0, rdv[31:16]});
        wr(8'h0c, 32'h0032_0064);
        $display("test setpoint done");
    endtask : t_clamp
    task automatic t_sleep();
        wr(8'h14, 32'h0000_0028);
        wr(8'h18, 32'h0003_0000);
        wr(8'h1c, 32'h0000_01f4);
        setpv(16'h0028);
        tk(10);
        flag("sleep off at zero delay", 1'b0, sleeping);
        setpv(16'h0014);
        wr(8'h1c, 32'h0005_01f4);
        // condition pulses shorter than five ticks must not add up
        repeat (2) begin
            setpv(16'h0028);
            repeat (25) @(posedge pclk);
            pv <= 16'h0014;
            repeat (20) @(posedge pclk);
        end
        flag("timer restarts", 1'b0, sleeping);
        setpv(16'h0028);
        tk(8);
        flag("threshold sleep", 1'b1, sleeping);
        for (int i = 0; i < 6000 && freq_cmd !== 16'h0000; i++)
            @(posedge pclk);
        tk(0);
        chk("stop in sleep", 32'h0, {16'h0, freq_cmd});
        setpv(16'h0005);
        tk(1);
        flag("wake not early", 1'b1, sleeping);
        tk(5);
        flag("error wake", 1'b0, sleeping);
        $display("test sleep done");
    endtask : t_sleep
    task automatic t_wake();
        wr(8'h28, 32'h03e8_1388);
        wr(8'h00, 32'h0000_0079);
        wr(8'h14, 32'h0014_0028);
        setpv(16'h001e);
        tk(8);
        chk("sleep at lower limit", 32'h0000_03e8, {16'h0, freq_cmd});
        tk(6);
        flag("error wake first", 1'b1, sleeping);
        // long sleep delay keeps the woken drive from dozing off again
        wr(8'h1c, 32'h0fff_01f4);
        wr(8'h14, 32'h0014_0000);
        tk(5);
        flag("feedback wake", 1'b0, sleeping);
        // frequency sleep, hysteresis left at its nonzero reset value
        wr(8'h14, 32'h0000_0000);
        wr(8'h24, 32'h1388_1388);
        wr(8'h1c, 32'h0005_0000);
        setpv(16'h0032);
        tk(8);
        flag("frequency sleep", 1'b1, sleeping);
        wr(8'h00, 32'h0000_0078);
        tk(2);
        flag("regulation off", 1'b0, regulating);
        $display("test wake done");
    endtask : t_wake

    // --------
    // run and verdict
    // --------
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 40000) begin
            n_errors++;
            final_report();
        end
    end
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_start();
        t_pol();
        t_dband();
        t_clamp();
        t_sleep();
        t_wake();
        final_report();
    end
endmodule : pss_top_tb_top
